// file: pdi_cfg.svh
// constants for the prescaler divider init block: offsets, fields, reset values, counts
// assumes inclusion by bare name from the design file
`ifndef PDI_CFG_SVH
`define PDI_CFG_SVH
`define PDI_ADDR_PRESCALER_CONTROL 4'h0
`define PDI_ADDR_OSCILLATOR_CONTROL 4'h1
`define PDI_ADDR_RC_TRIM 4'h2
`define PDI_ADDR_STATUS 4'h3
`define PDI_BIT_RESET_CMD 0
`define PDI_BIT_CPU_VIEW 1
`define PDI_BIT_CRYSTAL_ENABLE 1
`define PDI_BIT_EXT_CLOCK_SEL 5
`define PDI_PRESCALER_CONTROL_RESET 8'h00
`define PDI_OSCILLATOR_CONTROL_RESET 8'h00
`define PDI_RC_TRIM_RESET 8'h00
`define PDI_HF_STAGES 8
`define PDI_LF_STAGES 15
`define PDI_CRYSTAL_HZ 32768
`define PDI_CLOCK_HZ 100000000
`define PDI_CRYSTAL_DIV (`PDI_CLOCK_HZ / (2 * `PDI_CRYSTAL_HZ))
`define PDI_COLD_START_CYCLES 32768
`endif

// file: pdi_pkg.sv
// types shared by the prescaler divider init block
// assumes nothing of its surroundings
`default_nettype none
package pdi_pkg;
    typedef enum logic [1:0] {
        PDI_IDLE,
        PDI_SYNC,
        PDI_CLEAR
    } pdi_lf_init_e;
endpackage
`default_nettype wire

// file: pdi_top.sv
// prescaler divider chain with its initialization structure and control registers
// assumes one 100 MHz clock; rc and external clocks arrive as enable pulses, the crystal is emulated from the clock
`timescale 1ns/1ps
`default_nettype none
`include "pdi_cfg.svh"
module pdi_top (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    input wire logic rc_tick,
    input wire logic ext_tick,
    input wire logic sleep_mode,
    input wire logic test_mode,
    input wire logic cpu_clock_in,
    output logic [`PDI_HF_STAGES-1:0] hf_divider,
    output logic [`PDI_LF_STAGES-1:0] lf_divider,
    output logic low_freq_input_clock,
    output logic cold_start_busy
);
    import pdi_pkg::*;

    // ------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------
    logic [7:0] osc_q;
    logic [7:0] trim_q;
    logic reset_cmd_q;
    logic xtal_start_q;
    logic crystal_enable;
    logic ext_sel;
    logic [`PDI_HF_STAGES-1:0] hf_q;
    logic [`PDI_LF_STAGES-1:0] lf_q;
    logic lf_clk_q;
    logic [15:0] cold_cnt_q;
    logic cold_q;
    logic lf_init_q;
    pdi_lf_init_e lf_state_q;

    assign crystal_enable = osc_q[`PDI_BIT_CRYSTAL_ENABLE];
    assign ext_sel = osc_q[`PDI_BIT_EXT_CLOCK_SEL];

    // ------------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------------
    // one address compare per register, shared by the pulse detectors below
    logic wr_ctrl;
    logic wr_osc;
    logic wr_trim;
    assign wr_ctrl = wr_en && (addr == `PDI_ADDR_PRESCALER_CONTROL);
    assign wr_osc = wr_en && (addr == `PDI_ADDR_OSCILLATOR_CONTROL);
    assign wr_trim = wr_en && (addr == `PDI_ADDR_RC_TRIM);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            osc_q <= `PDI_OSCILLATOR_CONTROL_RESET;
            trim_q <= `PDI_RC_TRIM_RESET;
        end else begin
            if (wr_osc) begin
                osc_q <= wdata;
            end
            if (wr_trim) begin
                trim_q <= wdata;
            end
        end
    end

    // write of zero ignored, never stored
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            reset_cmd_q <= 1'b0;
        end else begin
            reset_cmd_q <= wr_ctrl && wdata[`PDI_BIT_RESET_CMD];
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            xtal_start_q <= 1'b0;
        end else begin
            xtal_start_q <= wr_osc && wdata[`PDI_BIT_CRYSTAL_ENABLE] && !crystal_enable;
        end
    end

    // bits 7-2 zero, bit 1 test view, bit 0 reads zero
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= 8'h00;
        end else if (rd_en) begin
            case (addr)
                `PDI_ADDR_PRESCALER_CONTROL:
                    rdata <= {6'h00, test_mode & cpu_clock_in, 1'b0};
                `PDI_ADDR_OSCILLATOR_CONTROL: rdata <= osc_q;
                `PDI_ADDR_RC_TRIM: rdata <= trim_q;
                `PDI_ADDR_STATUS: begin
                    rdata <= {5'h00, lf_init_q, cold_q, lf_clk_q};
                end
                default: rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // crystal emulation and cold start
    // ------------------------------------------------------------------
    localparam int XDIV = `PDI_CRYSTAL_DIV;
    logic [15:0] xdiv_q;
    logic xtal_tick;
    assign xtal_tick = crystal_enable && (xdiv_q == 16'(XDIV - 1));

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            xdiv_q <= 16'h0000;
        end else if (!crystal_enable || xtal_tick) begin
            xdiv_q <= 16'h0000;
        end else begin
            xdiv_q <= xdiv_q + 16'h0001;
        end
    end

    // cold start counts crystal half periods after enabling
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cold_cnt_q <= 16'h0000;
            cold_q <= 1'b0;
        end else if (xtal_start_q) begin
            cold_cnt_q <= 16'h0000;
            cold_q <= 1'b1;
        end else if (!crystal_enable) begin
            cold_q <= 1'b0;
        end else if (cold_q && xtal_tick) begin
            cold_cnt_q <= cold_cnt_q + 16'h0001;
            if (cold_cnt_q == 16'(`PDI_COLD_START_CYCLES - 1)) begin
                cold_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // high-frequency divider
    // ------------------------------------------------------------------
    logic hf_init;
    logic hf_run;
    logic hf_release_q;
    // high part has its own init
    assign hf_init = sleep_mode;
    assign hf_run = ext_sel ? ext_tick : rc_tick;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            hf_q <= '0;
            hf_release_q <= 1'b0;
        end else if (hf_init) begin
            hf_q <= '0;
            hf_release_q <= 1'b0;
        end else if (hf_run) begin
            hf_q <= hf_q + 8'h01;
            hf_release_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // rc division factor and low clock selection
    // ------------------------------------------------------------------
    logic [2:0] div_log;
    logic [3:0] coarse;
    logic range_sel;
    logic rc_lf_tick;
    logic [2:0] div_log_q;
    assign coarse = trim_q[3:0];
    assign range_sel = trim_q[4];

    // factor from range and coarse trim
    always_comb begin
        div_log = 3'd5;
        if (!range_sel) begin
            if (coarse == 4'h0) div_log = 3'd1;
            else if (coarse == 4'h1) div_log = 3'd2;
            else if (coarse <= 4'h3) div_log = 3'd3;
            else if (coarse <= 4'h8) div_log = 3'd4;
            else div_log = 3'd5;
        end else begin
            if (coarse == 4'h0) div_log = 3'd5;
            else if (coarse <= 4'h2) div_log = 3'd6;
            else div_log = 3'd7;
        end
    end

    // factor applied only when hf_q[6:0] wraps or during hf_init, so no short pulse
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            div_log_q <= 3'd1;
        end else if (hf_run && (hf_q[6:0] == 7'h7F || hf_init)) begin
            div_log_q <= div_log;
        end else if (hf_init) begin
            div_log_q <= div_log;
        end
    end

    // ------------------------------------------------------------------
    // rc-derived low clock
    // ------------------------------------------------------------------
    // each lf_tick is half a low clock period, so the mask spans half the
    // factor; a factor of two therefore ticks on every rc edge
    logic [7:0] wrap_mask;
    assign wrap_mask = 8'(((9'h001 << div_log_q) - 9'h001) >> 1);
    assign rc_lf_tick = hf_run && ((hf_q & wrap_mask) == wrap_mask);

    logic lf_tick;
    // crystal feeds the chain when enabled
    assign lf_tick = crystal_enable ? xtal_tick : rc_lf_tick;

    // ------------------------------------------------------------------
    // low-frequency init structure
    // ------------------------------------------------------------------
    logic init_req_q;
    logic soft_req;
    logic xtal_req;
    // software clear dropped during cold start
    // keeping the count intact matters more than honouring a late command
    assign soft_req = reset_cmd_q && !cold_q;
    // crystal start always asks for an init
    assign xtal_req = xtal_start_q;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            init_req_q <= 1'b0;
        end else if (soft_req || xtal_req) begin
            init_req_q <= 1'b1;
        end else if (lf_state_q == PDI_CLEAR && lf_tick) begin
            init_req_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // low init sequencer
    // ------------------------------------------------------------------
    logic lf_release_ok;
    // external clock: wait for high release
    // holding the low part avoids it starting on a high chain still in init
    assign lf_release_ok = !ext_sel || hf_release_q;

    // request applied on a low clock edge
    // clear completes at the first lf_tick with lf_release_ok, half a low period later unless ext_sel waits on hf_release_q
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            lf_state_q <= PDI_IDLE;
            lf_init_q <= 1'b0;
        end else begin
            case (lf_state_q)
                PDI_IDLE: begin
                    lf_init_q <= 1'b0;
                    if (init_req_q) begin
                        lf_state_q <= PDI_SYNC;
                    end
                end
                PDI_SYNC: begin
                    if (lf_tick) begin
                        lf_state_q <= PDI_CLEAR;
                        lf_init_q <= 1'b1;
                    end
                end
                PDI_CLEAR: begin
                    if (lf_tick && lf_release_ok) begin
                        lf_state_q <= PDI_IDLE;
                        lf_init_q <= 1'b0;
                    end
                end
                default: begin
                    lf_state_q <= PDI_IDLE;
                    lf_init_q <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // low-frequency chain
    // ------------------------------------------------------------------
    logic lf_clear;
    // crystal start clear lands even while cold
    // clear wins over counting, so a tick in the clear cycle is dropped
    assign lf_clear = sleep_mode || lf_init_q;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            lf_q <= '0;
            lf_clk_q <= 1'b0;
        end else if (lf_clear) begin
            lf_q <= '0;
            lf_clk_q <= 1'b0;
        end else if (lf_tick) begin
            lf_clk_q <= ~lf_clk_q;
            if (lf_clk_q) begin
                lf_q <= lf_q + 15'h0001;
            end
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            hf_divider <= '0;
            lf_divider <= '0;
            low_freq_input_clock <= 1'b0;
            cold_start_busy <= 1'b0;
        end else begin
            hf_divider <= hf_q;
            lf_divider <= lf_q;
            low_freq_input_clock <= lf_clk_q;
            cold_start_busy <= cold_q;
        end
    end
endmodule // pdi_top
`default_nettype wire

// file: pdi_top_asserts.sv
// port assertions for pdi_top
// assumes the bind below and one clock domain
`timescale 1ns/1ps
`default_nettype none
module pdi_top_asserts (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [3:0] addr,
    input wire logic rd_en,
    input wire logic [7:0] rdata,
    input wire logic rc_tick,
    input wire logic ext_tick,
    input wire logic sleep_mode,
    input wire logic test_mode,
    input wire logic cpu_clock_in,
    input wire logic [7:0] hf_divider,
    input wire logic [14:0] lf_divider
);
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    // ----------------------------------------
    // divider state
    // ----------------------------------------
    a_cold_zero: assert property (
        $rose(arst_n) |-> hf_divider == 8'h00 && lf_divider == 15'h0000)
        else $error("dividers not zero after reset");
    a_sleep_hold: assert property (
        sleep_mode [*3] |-> hf_divider == 8'h00 && lf_divider == 15'h0000)
        else $error("dividers not held in sleep");
    // no rc or external tick means the high part must not move, whatever the low part does
    a_hf_idle_stable: assert property (
        (!rc_tick && !ext_tick && !sleep_mode) [*3] |-> $stable(hf_divider))
        else $error("high divider moved without tick");
    // ----------------------------------------
    // register reads
    // ----------------------------------------
    a_ctrl_zero_bits: assert property (
        rd_en && addr == 4'h0 |=> rdata[7:2] == 6'h00 && rdata[0] == 1'b0)
        else $error("control read shows stored bits");
    a_view_masked: assert property (
        rd_en && addr == 4'h0 && !test_mode |=> rdata[1] == 1'b0)
        else $error("cpu view visible outside test mode");
    a_view_live: assert property (
        rd_en && addr == 4'h0 && test_mode && cpu_clock_in |=> rdata[1] == 1'b1)
        else $error("cpu view missing in test mode");
    a_rdata_quiet: assert property (
        !rd_en |=> rdata == 8'h00)
        else $error("read data without read");
    a_unmapped_read: assert property (
        rd_en && addr > 4'h3 |=> rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule // pdi_top_asserts
bind pdi_top pdi_top_asserts u_chk (.clock(clock), .arst_n(arst_n), .addr(addr),
    .rd_en(rd_en), .rdata(rdata), .rc_tick(rc_tick), .ext_tick(ext_tick),
    .sleep_mode(sleep_mode), .test_mode(test_mode), .cpu_clock_in(cpu_clock_in),
    .hf_divider(hf_divider), .lf_divider(lf_divider));
`default_nettype wire

// file: pdi_top_tb.sv
// bench for pdi_top: reads, divider rates, clears, sleep, crystal start
// assumes pdi_top and its checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module pdi_top_tb;
    logic clock = 1'b0, arst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, rc_tick = 1'b0;
    logic sleep_mode = 1'b0, test_mode = 1'b0, cpu_clock_in = 1'b0, rc_on = 1'b0;
    logic ext_on = 1'b0, ext_tick = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, rdata, hf_divider;
    logic [14:0] lf_divider, lf_a, delta;
    logic low_freq_input_clock, cold_start_busy, seen, ok;
    logic [3:0] cse [12] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h9, 4'hF,
        4'h0, 4'h1, 4'h2, 4'h3, 4'h6};
    int fac [12] = '{2, 4, 8, 16, 16, 32, 32, 32, 64, 64, 128, 128};
    logic [11:0] rng = 12'hF80;
    int fails = 0, checked = 0, e;
    always #5 clock = ~clock;
    always @(posedge clock) rc_tick <= rc_on;
    always @(posedge clock) ext_tick <= ext_on;
    pdi_top dut (.clock(clock), .arst_n(arst_n), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .rc_tick(rc_tick), .ext_tick(ext_tick),
        .sleep_mode(sleep_mode), .test_mode(test_mode), .cpu_clock_in(cpu_clock_in),
        .hf_divider(hf_divider), .lf_divider(lf_divider),
        .low_freq_input_clock(low_freq_input_clock), .cold_start_busy(cold_start_busy));
    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [14:0] exp, input logic [14:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] x);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1 chk($sformatf("register %h", a), {7'h00, x}, {7'h00, rdata & m});
    endtask
    task automatic wait_zero(input int lim);
        seen = 1'b0;
        for (int i = 0; i < lim && !seen; i++) begin
            @(posedge clock);
            #1 seen = (lf_divider === 15'h0000);
        end
    endtask
    task automatic do_reset();
        @(posedge clock);
        arst_n <= 1'b0;
        repeat (16) @(posedge clock);
        arst_n <= 1'b1;
        #1;
    endtask
    task automatic close_out();
        $display("counts: %0d checked, %0d fails", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        do_reset();
        chk("hf", 15'h0000, {7'h00, hf_divider});
        chk("lf", 15'h0000, lf_divider);
        rdchk(4'h0, 8'hFF, 8'h00);
        rdchk(4'h1, 8'hFF, 8'h00);
        rdchk(4'h2, 8'hFF, 8'h00);
        wr(4'hF, 8'hFF);
        rdchk(4'hF, 8'hFF, 8'h00);
        wr(4'h0, 8'hFF);
        rdchk(4'h0, 8'hFF, 8'h00);
        @(posedge clock);
        test_mode <= 1'b1;
        cpu_clock_in <= 1'b1;
        rdchk(4'h0, 8'hFF, 8'h02);
        @(posedge clock);
        test_mode <= 1'b0;
        rdchk(4'h0, 8'hFF, 8'h00);
        $display("test registers done");
        rc_on <= 1'b1;
        // settle past an hf wrap, since outside sleep the factor only changes there
        for (int k = 0; k < 12; k++) begin
            wr(4'h2, {3'h0, rng[k], cse[k]});
            repeat (600) @(posedge clock);
            #1 lf_a = lf_divider;
            repeat (1024) @(posedge clock);
            #1 delta = lf_divider - lf_a;
            e = 1024 / fac[k];
            ok = (delta + 15'd2 >= 15'(e)) && (delta <= 15'(e + 2));
            chk($sformatf("lf rate %0d", k), 15'h0001, {14'h0, ok});
        end
        $display("test rates done");
        wr(4'h2, 8'h00);
        repeat (600) @(posedge clock);
        wr(4'h0, 8'h00);
        wait_zero(12);
        chk("lf kept", 15'h0000, {14'h0, seen});
        wr(4'h0, 8'h01);
        wait_zero(12);
        chk("lf cleared", 15'h0001, {14'h0, seen});
        if (seen !== 1'b1) close_out();
        $display("test clear done");
        @(posedge clock);
        sleep_mode <= 1'b1;
        repeat (4) @(posedge clock);
        #1 chk("sleep hf", 15'h0000, {7'h00, hf_divider});
        chk("sleep lf", 15'h0000, lf_divider);
        @(posedge clock);
        sleep_mode <= 1'b0;
        $display("test sleep done");
        repeat (200) @(posedge clock);
        wr(4'h1, 8'h02);
        rdchk(4'h3, 8'h02, 8'h02);
        wait_zero(8000);
        chk("crystal init", 15'h0001, {14'h0, seen});
        if (seen !== 1'b1) close_out();
        repeat (6000) @(posedge clock);
        #1 chk("xtal lf run", 15'h0001, {14'h0, lf_divider != 15'h0000});
        wr(4'h0, 8'h01);
        wait_zero(3200);
        chk("cold clear ignored", 15'h0000, {14'h0, seen});
        chk("cold busy", 15'h0001, {14'h0, cold_start_busy});
        do_reset();
        chk("cold after reset", 15'h0000, {14'h0, cold_start_busy});
        rdchk(4'h1, 8'hFF, 8'h00);
        $display("test crystal done");
        rc_on <= 1'b0;
        wr(4'h1, 8'h20);
        ext_on <= 1'b1;
        repeat (40) @(posedge clock);
        #1 chk("ext run", 15'h0001, {14'h0, lf_divider != 15'h0000});
        wr(4'h0, 8'h01);
        wait_zero(12);
        chk("ext clear", 15'h0001, {14'h0, seen});
        $display("test external done");
        close_out();
    end
endmodule // pdi_top_tb
`default_nettype wire
